// ==== rtl/ctr_defines.vh ====
// constants shared by the control-transfer recorder files
`ifndef CTR_DEFINES_VH
`define CTR_DEFINES_VH

// sizes
`define CTR_PCW 64
`define CTR_DEPTH 16
`define CTR_DEPTH_C 5'h10
`define CTR_AW 4
`define CTR_EW 143
`define CTR_CCW 12
`define CTR_CC_MAX 12'hFFF
`define CTR_CC_ZERO 12'h000
`define CTR_CC_ONE 12'h001

// entry packing: src pc[63:1], tgt pc[63:1], type, ccv, cycle count
`define CTR_E_CC 11:0
`define CTR_E_CCV 12
`define CTR_E_TYPE 16:13
`define CTR_E_TGT 79:17
`define CTR_E_SRC 142:80

// control word, low half
`define CTR_F_U 0
`define CTR_F_S 1
`define CTR_F_M 2
`define CTR_F_MTE 6
`define CTR_F_STE 7
`define CTR_F_OVF_FRZ 11
`define CTR_F_BP_FRZ 12
`define CTR_HLO_MASK 32'h000018C7
`define CTR_VLO_MASK 32'h00000083
`define CTR_CTL_RST 32'h00000000
// control word, high half: transfer type filter bits 47:32
`define CTR_FILT 15:0
`define CTR_HI_MASK 32'h0000FFFF

// transfer types
`define CTR_T_NONE 4'h0
`define CTR_T_EXC 4'h1
`define CTR_T_INT 4'h2
`define CTR_T_RET 4'h3
`define CTR_T_NTB 4'h4
`define CTR_T_RSV6 4'h6
`define CTR_T_RSV7 4'h7

// privilege codes and nesting levels
`define CTR_PRV_U 2'h0
`define CTR_PRV_S 2'h1
`define CTR_PRV_M 2'h3
`define CTR_LVL_VU 2'h0
`define CTR_LVL_VS 2'h1
`define CTR_LVL_U 2'h1
`define CTR_LVL_S 2'h2
`define CTR_LVL_M 2'h3

// register byte offsets
`define CTR_A_HCTL_LO 8'h00
`define CTR_A_HCTL_HI 8'h04
`define CTR_A_VCTL_LO 8'h08
`define CTR_A_VCTL_HI 8'h0C
`define CTR_A_STATUS 8'h10
`define CTR_A_CLEAR 8'h14
`define CTR_A_ESEL 8'h18
`define CTR_A_ESRC_LO 8'h1C
`define CTR_A_ESRC_HI 8'h20
`define CTR_A_ETGT_LO 8'h24
`define CTR_A_ETGT_HI 8'h28
`define CTR_A_EDATA 8'h2C
`define CTR_ST_FROZEN 0
`define CTR_ST_CNT 12:8
`define CTR_D_CC 27:16
`define CTR_D_CCV 15
`define CTR_D_TYPE 3:0
`define CTR_ZERO32 32'h00000000

`endif

// ==== rtl/ctr_entry_mem.v ====
// entry storage for the recorder, registered read port
`timescale 1ns/1ps
`include "ctr_defines.vh"
module ctr_entry_mem (
    input wire clk_i,
    input wire we_i,
    input wire [`CTR_AW-1:0] waddr_i,
    input wire [`CTR_EW-1:0] wdata_i,
    input wire [`CTR_AW-1:0] raddr_i,
    output reg [`CTR_EW-1:0] rdata_o
);

reg [`CTR_EW-1:0] mem [0:`CTR_DEPTH-1];

always @(posedge clk_i) begin
    if (we_i) begin
        mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
end

endmodule // ctr_entry_mem

// ==== rtl/ctr_recorder.v ====
// control-transfer recorder: qualification, entry stack and register slave
`timescale 1ns/1ps
`include "ctr_defines.vh"

module ctr_recorder (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire ret_valid_i,
    input wire [3:0] ret_type_i,
    input wire [`CTR_PCW-1:0] ret_src_pc_i,
    input wire [`CTR_PCW-1:0] ret_tgt_pc_i,
    input wire [1:0] ret_src_priv_i,
    input wire ret_src_virt_i,
    input wire [1:0] ret_tgt_priv_i,
    input wire ret_tgt_virt_i,
    input wire [1:0] cur_priv_i,
    input wire cur_virt_i,
    input wire debug_mode_i,
    input wire ret_debug_i,
    input wire clear_i,
    input wire ovf_irq_i,
    input wire breakpoint_i,
    output reg frozen_o,
    output reg rec_push_o
);

// ****************************************
// state
// ****************************************
reg [31:0] hctl_lo;
reg [31:0] hctl_hi;
reg [31:0] vctl_lo;
reg [31:0] vctl_hi;
reg [`CTR_AW-1:0] esel;
reg [`CTR_AW-1:0] wptr;
reg [4:0] count;
reg [`CTR_CCW-1:0] cycles;
reg ccv_ok;
reg rd_valid;
wire [`CTR_EW-1:0] rd_entry;

// ****************************************
// helpers
// ****************************************
function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0] sel;
    input [31:0] mask;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        merge = merge & mask;
    end
endfunction

// per-privilege enables, indexed by privilege code
wire [3:0] host_en = {hctl_lo[`CTR_F_M], 1'b0, hctl_lo[`CTR_F_S],
                      hctl_lo[`CTR_F_U]};
wire [3:0] guest_en = {2'b00, vctl_lo[`CTR_F_S], vctl_lo[`CTR_F_U]};
// nesting level: VU below VS/U below S/HS below M
wire [7:0] host_lvl = {`CTR_LVL_M, `CTR_LVL_U, `CTR_LVL_S, `CTR_LVL_U};
wire [7:0] guest_lvl = {`CTR_LVL_VU, `CTR_LVL_VU, `CTR_LVL_VS, `CTR_LVL_VU};

// ****************************************
// qualification
// ****************************************
// enables from host and guest words
wire src_en = ret_src_virt_i ? guest_en[ret_src_priv_i] :
              host_en[ret_src_priv_i];
wire tgt_en = ret_tgt_virt_i ? guest_en[ret_tgt_priv_i] :
              host_en[ret_tgt_priv_i];
wire cur_en = cur_virt_i ? guest_en[cur_priv_i] : host_en[cur_priv_i];
wire [2:0] src_ix = {ret_src_priv_i, 1'b0};
wire [2:0] tgt_ix = {ret_tgt_priv_i, 1'b0};
wire [1:0] src_lvl = ret_src_virt_i ? guest_lvl[src_ix +: 2] :
                     host_lvl[src_ix +: 2];
wire [1:0] tgt_lvl = ret_tgt_virt_i ? guest_lvl[tgt_ix +: 2] :
                     host_lvl[tgt_ix +: 2];

// opt-in bit per level from host word and guest word
wire [3:0] lvl_te;
assign lvl_te[0] = 1'b0;
assign lvl_te[`CTR_LVL_VS] = vctl_lo[`CTR_F_STE];
assign lvl_te[`CTR_LVL_S] = hctl_lo[`CTR_F_STE];
assign lvl_te[`CTR_LVL_M] = hctl_lo[`CTR_F_MTE];

// every level above source up to target must opt in
wire [3:0] lvl_ok;
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_lvl
        assign lvl_ok[g] = !((src_lvl < g) && (tgt_lvl >= g)) ||
                           lvl_te[g];
    end
endgenerate
wire ext_ok = &lvl_ok;

// filter bits from the guest word when virtualization is involved
wire use_vs = ret_src_virt_i | ret_tgt_virt_i;
wire [15:0] filt = use_vs ? vctl_hi[`CTR_FILT] : hctl_hi[`CTR_FILT];
// not-taken branches opt in, the rest opt out
wire inhibit = (ret_type_i == `CTR_T_NTB) ? !filt[ret_type_i] :
               filt[ret_type_i];
wire type_ok = (ret_type_i != `CTR_T_NONE) &&
               (ret_type_i != `CTR_T_RSV6) &&
               (ret_type_i != `CTR_T_RSV7);
wire is_trap = (ret_type_i == `CTR_T_EXC) || (ret_type_i == `CTR_T_INT);
wire is_ret = (ret_type_i == `CTR_T_RET);

reg next_take;
reg next_zero_src;
reg next_zero_tgt;
always @* begin
    next_take = 1'b0;
    next_zero_src = 1'b0;
    next_zero_tgt = 1'b0;
    if (is_trap) begin
        if (src_en && tgt_en) begin
            next_take = !inhibit;
        end else if (tgt_en) begin
            next_take = !inhibit;
            next_zero_src = 1'b1;
        end else if (src_en) begin
            next_take = ext_ok;
            next_zero_tgt = 1'b1;
        end
    end else if (is_ret) begin
        if (src_en) begin
            next_take = !inhibit;
            next_zero_tgt = !tgt_en;
        end
    end else begin
        next_take = src_en && !inhibit && type_ok;
    end
end

// purely combinational, no feedback to retirement
wire record = ret_valid_i && next_take && !frozen_o &&
              !debug_mode_i && !ret_debug_i;

// ****************************************
// register bus decode
// ****************************************
wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wr = req && wb_we_i;
wire wr_hlo = wr && (wb_adr_i == `CTR_A_HCTL_LO);
wire wr_hhi = wr && (wb_adr_i == `CTR_A_HCTL_HI);
wire wr_vlo = wr && (wb_adr_i == `CTR_A_VCTL_LO);
wire wr_vhi = wr && (wb_adr_i == `CTR_A_VCTL_HI);
wire wr_ctl = wr_hlo || wr_hhi || wr_vlo || wr_vhi;
wire wr_clr = wr && (wb_adr_i == `CTR_A_CLEAR) && wb_sel_i[0] &&
              wb_dat_i[0];
wire clear = clear_i || wr_clr;
wire unfreeze = wr && (wb_adr_i == `CTR_A_STATUS) && wb_sel_i[0] &&
                !wb_dat_i[`CTR_ST_FROZEN];
// freeze controls from the host word
wire freeze = (ovf_irq_i && hctl_lo[`CTR_F_OVF_FRZ]) ||
              (breakpoint_i && hctl_lo[`CTR_F_BP_FRZ]);

always @(posedge clk_i) begin
    if (rst_i) begin
        hctl_lo <= `CTR_CTL_RST;
        hctl_hi <= `CTR_CTL_RST;
        vctl_lo <= `CTR_CTL_RST;
        vctl_hi <= `CTR_CTL_RST;
        esel <= {`CTR_AW{1'b0}};
    end else begin
        if (wr_hlo) begin
            hctl_lo <= merge(hctl_lo, wb_dat_i, wb_sel_i, `CTR_HLO_MASK);
        end
        if (wr_hhi) begin
            hctl_hi <= merge(hctl_hi, wb_dat_i, wb_sel_i, `CTR_HI_MASK);
        end
        if (wr_vlo) begin
            vctl_lo <= merge(vctl_lo, wb_dat_i, wb_sel_i, `CTR_VLO_MASK);
        end
        if (wr_vhi) begin
            vctl_hi <= merge(vctl_hi, wb_dat_i, wb_sel_i, `CTR_HI_MASK);
        end
        if (wr && (wb_adr_i == `CTR_A_ESEL) && wb_sel_i[0]) begin
            esel <= wb_dat_i[`CTR_AW-1:0];
        end
    end
end

// frozen: a freeze event wins over a software unfreeze
always @(posedge clk_i) begin
    if (rst_i) begin
        frozen_o <= 1'b0;
    end else if (freeze) begin
        frozen_o <= 1'b1;
    end else if (unfreeze) begin
        frozen_o <= 1'b0;
    end
end

// ****************************************
// entry stack
// ****************************************
// circular store: newest at wptr-1, oldest overwritten
// at most one push per cycle, taken in retirement order
always @(posedge clk_i) begin
    if (rst_i) begin
        wptr <= {`CTR_AW{1'b0}};
        count <= 5'h00;
        rec_push_o <= 1'b0;
    end else begin
        rec_push_o <= record;
        if (clear) begin
            count <= 5'h00;
        end else if (record && (count != `CTR_DEPTH_C)) begin
            count <= count + 5'h01;
        end
        if (record) begin
            wptr <= wptr + 1'b1;
        end
    end
end

// elapsed cycles while active, restart on control write or clear
always @(posedge clk_i) begin
    if (rst_i) begin
        cycles <= `CTR_CC_ZERO;
        ccv_ok <= 1'b0;
    end else if (wr_ctl || clear) begin
        cycles <= `CTR_CC_ZERO;
        ccv_ok <= !clear && ccv_ok;
    end else if (record) begin
        cycles <= `CTR_CC_ZERO;
        ccv_ok <= 1'b1;
    end else if (cur_en && !frozen_o && !debug_mode_i &&
                 (cycles != `CTR_CC_MAX)) begin
        cycles <= cycles + `CTR_CC_ONE;
    end
end

// fill every field, forcing pcs to zero as decided
wire [`CTR_EW-1:0] wentry = {
    next_zero_src ? {(`CTR_PCW-1){1'b0}} : ret_src_pc_i[`CTR_PCW-1:1],
    next_zero_tgt ? {(`CTR_PCW-1){1'b0}} : ret_tgt_pc_i[`CTR_PCW-1:1],
    ret_type_i, ccv_ok, cycles};
wire [`CTR_AW-1:0] raddr = wptr - esel - 1'b1;

ctr_entry_mem u_mem (
    .clk_i(clk_i),
    .we_i(record),
    .waddr_i(wptr),
    .wdata_i(wentry),
    .raddr_i(raddr),
    .rdata_o(rd_entry)
);

// entries beyond the occupied depth read as zero
always @(posedge clk_i) begin
    if (rst_i) begin
        rd_valid <= 1'b0;
    end else begin
        rd_valid <= ({1'b0, esel} < count);
    end
end

// ****************************************
// read mux and acknowledge
// ****************************************
wire [`CTR_PCW-1:0] e_src = {rd_entry[`CTR_E_SRC], 1'b0};
wire [`CTR_PCW-1:0] e_tgt = {rd_entry[`CTR_E_TGT], 1'b0};
reg [31:0] next_rdata;
always @* begin
    next_rdata = `CTR_ZERO32;
    case (wb_adr_i)
        `CTR_A_HCTL_LO: next_rdata = hctl_lo;
        `CTR_A_HCTL_HI: next_rdata = hctl_hi;
        `CTR_A_VCTL_LO: next_rdata = vctl_lo;
        `CTR_A_VCTL_HI: next_rdata = vctl_hi;
        `CTR_A_STATUS: begin
            next_rdata[`CTR_ST_FROZEN] = frozen_o;
            next_rdata[`CTR_ST_CNT] = count;
        end
        `CTR_A_ESEL: next_rdata[`CTR_AW-1:0] = esel;
        `CTR_A_ESRC_LO: begin
            // valid bit rides in bit 0
            if (rd_valid) begin
                next_rdata = {e_src[31:1], 1'b1};
            end
        end
        `CTR_A_ESRC_HI: next_rdata = rd_valid ? e_src[63:32] : `CTR_ZERO32;
        `CTR_A_ETGT_LO: next_rdata = rd_valid ? e_tgt[31:0] : `CTR_ZERO32;
        `CTR_A_ETGT_HI: next_rdata = rd_valid ? e_tgt[63:32] : `CTR_ZERO32;
        `CTR_A_EDATA: begin
            if (rd_valid) begin
                next_rdata[`CTR_D_TYPE] = rd_entry[`CTR_E_TYPE];
                next_rdata[`CTR_D_CCV] = rd_entry[`CTR_E_CCV];
                next_rdata[`CTR_D_CC] = rd_entry[`CTR_E_CC];
            end
        end
        default: next_rdata = `CTR_ZERO32;
    endcase
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= `CTR_ZERO32;
    end else begin
        wb_ack_o <= req;
        if (req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end
end

endmodule // ctr_recorder

// ==== test/ctr_core_model.sv ====
// retirement stage model feeding transfers to the recorder
`timescale 1ns/1ps
module ctr_core_model (
    input wire clk_i,
    output logic valid_o,
    output logic [3:0] type_o,
    output logic [63:0] src_pc_o,
    output logic [63:0] tgt_pc_o,
    output logic [1:0] src_prv_o,
    output logic [1:0] tgt_prv_o,
    output logic dbg_o,
    output logic dbg_xfer_o
);
    initial begin
        valid_o = 1'b0;
        type_o = 4'h0;
        src_pc_o = 64'h0;
        tgt_pc_o = 64'h0;
        src_prv_o = 2'h3;
        tgt_prv_o = 2'h3;
        dbg_o = 1'b0;
        dbg_xfer_o = 1'b0;
    end
    task automatic retire(input logic [3:0] t, input logic [1:0] s,
            input logic [1:0] d, input logic [1:0] g, input logic [31:0] p);
        @(posedge clk_i);
        valid_o <= 1'b1;
        type_o <= t;
        src_pc_o <= {32'hA5A50000, p};
        tgt_pc_o <= 64'hA5A5000000002200;
        src_prv_o <= s;
        tgt_prv_o <= d;
        {dbg_o, dbg_xfer_o} <= g;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // released pc fields are inverted so they no longer show the last values; type and privileges hold
        src_pc_o <= ~src_pc_o;
        tgt_pc_o <= ~tgt_pc_o;
        {dbg_o, dbg_xfer_o} <= 2'h0;
    endtask
endmodule // ctr_core_model

// ==== test/ctr_recorder_assertions.sv ====
// port-level checks for the control-transfer recorder
`timescale 1ns/1ps
module ctr_recorder_checker (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire wb_ack_o,
    input wire ret_valid_i,
    input wire [3:0] ret_type_i,
    input wire debug_mode_i,
    input wire ret_debug_i,
    input wire frozen_o,
    input wire rec_push_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_dbg;
        ret_valid_i && (debug_mode_i || ret_debug_i);
    endsequence
    sequence s_rsv;
        ret_valid_i && (ret_type_i inside {4'h0, 4'h6, 4'h7});
    endsequence

    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_IDLE: assert property
        (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    AST_PUSH_CAUSE: assert property (rec_push_o |-> $past(ret_valid_i))
        else $error("record pushed with no retired transfer");
    AST_DEBUG_BLOCK: assert property (s_dbg |=> !rec_push_o)
        else $error("transfer recorded in or across debug mode");
    AST_RSV_TYPE: assert property (s_rsv |=> !rec_push_o)
        else $error("unused transfer type recorded");
    AST_FROZEN_BLOCK: assert property
        (frozen_o && ret_valid_i |=> !rec_push_o)
        else $error("transfer recorded while frozen");
    AST_FREEZE_HOLD: assert property
        (frozen_o && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> frozen_o)
        else $error("freeze flag dropped without a write");
endmodule // ctr_recorder_checker

// ==== test/ctr_recorder_tb.sv ====
// self-checking bench for the control-transfer recorder
`timescale 1ns/1ps
`include "ctr_defines.vh"
module ctr_recorder_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0, ovf = 1'b0;
    logic bkp = 1'b0;
    logic vs = 1'b0, vt = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire ack, frozen, push, rv, dm, rdbg;
    wire [3:0] rt;
    wire [63:0] spc, tpc;
    wire [1:0] sp, tp;
    int error_cnt = 0;
    int compares = 0;
    always #4 clk_i = ~clk_i;

    ctr_recorder dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ret_valid_i(rv),
        .ret_type_i(rt), .ret_src_pc_i(spc), .ret_tgt_pc_i(tpc),
        .ret_src_priv_i(sp), .ret_src_virt_i(vs), .ret_tgt_priv_i(tp),
        .ret_tgt_virt_i(vt), .cur_priv_i(sp), .cur_virt_i(vs),
        .debug_mode_i(dm), .ret_debug_i(rdbg), .clear_i(clr),
        .ovf_irq_i(ovf), .breakpoint_i(bkp), .frozen_o(frozen),
        .rec_push_o(push));
    ctr_core_model core_u (.clk_i(clk_i), .valid_o(rv), .type_o(rt),
        .src_pc_o(spc), .tgt_pc_o(tpc), .src_prv_o(sp), .tgt_prv_o(tp),
        .dbg_o(dm), .dbg_xfer_o(rdbg));

    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic cnt(input logic [4:0] n);
        logic [31:0] q;
        wb(1'b0, `CTR_A_STATUS, 32'h0, q);
        chk({27'h0, q[12:8]}, {27'h0, n});
    endtask
    task automatic ent(input logic [3:0] i, input logic [31:0] s,
            input logic [31:0] t, input logic [3:0] ty);
        logic [31:0] q;
        wr(`CTR_A_ESEL, {28'h0, i});
        rd(`CTR_A_ESRC_LO, s);
        rd(`CTR_A_ETGT_LO, t);
        wb(1'b0, `CTR_A_EDATA, 32'h0, q);
        chk({28'h0, q[3:0]}, {28'h0, ty});
    endtask
    task automatic ccv(input logic e);
        logic [31:0] q;
        wb(1'b0, `CTR_A_EDATA, 32'h0, q);
        chk({31'h0, q[15]}, {31'h0, e});
    endtask
    task automatic xf(input logic [3:0] t, input logic [1:0] s,
            input logic [1:0] d, input logic [1:0] g, input logic [31:0] p,
            input logic e);
        core_u.retire(t, s, d, g, p);
        @(posedge clk_i);
        chk({31'h0, push}, {31'h0, e});
    endtask
    task automatic pulse(input int k);
        @(posedge clk_i);
        if (k == 0)
            ovf <= 1'b1;
        else if (k == 1)
            bkp <= 1'b1;
        else
            clr <= 1'b1;
        @(posedge clk_i);
        {ovf, bkp, clr} <= 3'h0;
        @(posedge clk_i);
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_regs();
        rd(`CTR_A_HCTL_LO, 32'h0);
        wr(`CTR_A_HCTL_LO, 32'hFFFFFFFF);
        rd(`CTR_A_HCTL_LO, `CTR_HLO_MASK);
        wr(`CTR_A_VCTL_LO, 32'hFFFFFFFF);
        rd(`CTR_A_VCTL_LO, `CTR_VLO_MASK);
        rd(8'hFC, 32'h0);
        $display("regs done");
    endtask
    task automatic t_types();
        logic rec;
        wr(`CTR_A_HCTL_LO, 32'h7);
        for (int t = 0; t < 16; t++) begin
            rec = !(t inside {0, 4, 6, 7});
            xf(t[3:0], 2'h3, 2'h3, 2'h0, 32'h100, rec);
        end
        cnt(5'h0C);
        ent(4'h0, 32'h101, 32'h2200, 4'hF);
        ent(4'h1, 32'h101, 32'h2200, 4'hE);
        wr(`CTR_A_HCTL_HI, 32'h0000FFFF);
        for (int t = 1; t < 16; t++)
            xf(t[3:0], 2'h3, 2'h3, 2'h0, 32'h100, t == 4);
        wr(`CTR_A_HCTL_HI, 32'h0);
        $display("types done");
    endtask
    task automatic t_depth();
        pulse(2);
        cnt(5'h00);
        for (int i = 0; i < 17; i++) begin
            xf(4'h5, 2'h3, 2'h3, 2'h0, 32'h1000 + 4 * i, 1'b1);
            if (i == 0) begin
                wr(`CTR_A_ESEL, 32'h0);
                ccv(1'b0);
            end
        end
        cnt(5'h10);
        ent(4'h0, 32'h1041, 32'h2200, 4'h5);
        ent(4'hF, 32'h1005, 32'h2200, 4'h5);
        ccv(1'b1);
        $display("depth done");
    endtask
    task automatic t_modes();
        wr(`CTR_A_HCTL_LO, 32'h2);
        xf(4'h1, 2'h0, 2'h1, 2'h0, 32'h100, 1'b1);
        ent(4'h0, 32'h1, 32'h2200, 4'h1);
        xf(4'h3, 2'h1, 2'h0, 2'h0, 32'h100, 1'b1);
        ent(4'h0, 32'h101, 32'h0, 4'h3);
        xf(4'h3, 2'h0, 2'h1, 2'h0, 32'h100, 1'b0);
        xf(4'h1, 2'h0, 2'h0, 2'h0, 32'h100, 1'b0);
        xf(4'h1, 2'h1, 2'h1, 2'h0, 32'h100, 1'b1);
        wr(`CTR_A_HCTL_HI, 32'h6);
        for (int i = 0; i < 4; i++) begin
            wr(`CTR_A_HCTL_LO, 32'h1 | (i << 6));
            xf(4'h2, 2'h0, 2'h3, 2'h0, 32'h100, i == 3);
        end
        ent(4'h0, 32'h101, 32'h0, 4'h2);
        wr(`CTR_A_HCTL_LO, 32'h42);
        xf(4'h1, 2'h1, 2'h3, 2'h0, 32'h100, 1'b1);
        xf(4'h1, 2'h1, 2'h1, 2'h0, 32'h100, 1'b0);
        wr(`CTR_A_HCTL_HI, 32'h0);
        $display("modes done");
    endtask
    task automatic t_virt();
        wr(`CTR_A_HCTL_LO, 32'h2);
        wr(`CTR_A_VCTL_LO, 32'h1);
        wr(`CTR_A_VCTL_HI, 32'h2);
        vs <= 1'b1;
        xf(4'h1, 2'h0, 2'h1, 2'h0, 32'h100, 1'b0);
        wr(`CTR_A_VCTL_HI, 32'h0);
        xf(4'h1, 2'h0, 2'h1, 2'h0, 32'h100, 1'b1);
        wr(`CTR_A_HCTL_LO, 32'h80);
        xf(4'h1, 2'h0, 2'h1, 2'h0, 32'h100, 1'b0);
        wr(`CTR_A_VCTL_LO, 32'h81);
        xf(4'h1, 2'h0, 2'h1, 2'h0, 32'h100, 1'b1);
        ent(4'h0, 32'h101, 32'h0, 4'h1);
        {vs, vt} <= 2'h1;
        wr(`CTR_A_VCTL_LO, 32'h0);
        wr(`CTR_A_HCTL_LO, 32'h2);
        xf(4'h3, 2'h1, 2'h0, 2'h0, 32'h100, 1'b1);
        ent(4'h0, 32'h101, 32'h0, 4'h3);
        {vs, vt} <= 2'h0;
        $display("virt done");
    endtask
    task automatic t_debug();
        wr(`CTR_A_HCTL_LO, 32'h1807);
        xf(4'h5, 2'h3, 2'h3, 2'h2, 32'h100, 1'b0);
        xf(4'h5, 2'h3, 2'h3, 2'h1, 32'h100, 1'b0);
        pulse(0);
        chk({31'h0, frozen}, 32'h1);
        xf(4'h5, 2'h3, 2'h3, 2'h0, 32'h100, 1'b0);
        wr(`CTR_A_STATUS, 32'h0);
        xf(4'h5, 2'h3, 2'h3, 2'h0, 32'h100, 1'b1);
        pulse(1);
        chk({31'h0, frozen}, 32'h1);
        $display("debug and freeze done");
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_types();
        t_depth();
        t_modes();
        t_virt();
        t_debug();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
endmodule // ctr_recorder_tb

bind ctr_recorder ctr_recorder_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .ret_valid_i(ret_valid_i), .ret_type_i(ret_type_i),
    .debug_mode_i(debug_mode_i), .ret_debug_i(ret_debug_i),
    .frozen_o(frozen_o), .rec_push_o(rec_push_o));
